/* File: pad_cfg.svh */
`ifndef PAD_CFG_SVH
`define PAD_CFG_SVH
// first instruction words, 10 bits
`define PAD_NOP   10'h000
`define PAD_POF   10'h002
`define PAD_POWERDOWN_FLAG_SKIP_INSTR  10'h003
`define PAD_RAM_BACKUP_ENTRY_INSTR  10'h008
`define PAD_RBK   10'h040
`define PAD_SBK   10'h041
`define PAD_POWERDOWN_ARM_INSTR  10'h05B
`define PAD_TJ1A  10'h202
`define PAD_TQ1A  10'h204
`define PAD_TL1A  10'h20A
`define PAD_TL2A  10'h20B
`define PAD_TK1A  10'h214
`define PAD_TMRA  10'h216
`define PAD_TK0A  10'h21B
`define PAD_TFR0A 10'h228
`define PAD_TSIAB 10'h238
`define PAD_COMPARATOR_WRITE_INSTR 10'h239
`define PAD_TAJ1  10'h242
`define PAD_TAQ1  10'h244
`define PAD_CONV_LOW_READ_INSTR  10'h249
`define PAD_TAL1  10'h24A
`define PAD_TAMR  10'h252
`define PAD_TAK0  10'h256
`define PAD_TAK1  10'h259
`define PAD_TABSI 10'h278
`define PAD_CONV_RESULT_READ_INSTR 10'h279
`define PAD_CONV_DONE_SKIP_INSTR 10'h287
`define PAD_SERIAL_DONE_SKIP_INSTR 10'h288
`define PAD_VOLTAGE_DROP_ENABLE_INSTR  10'h293
`define PAD_SELECT_CERAMIC_INSTR  10'h29A
`define PAD_SELECT_RC_INSTR  10'h29B
`define PAD_WATCHDOG_DISABLE_INSTR  10'h29C
`define PAD_SST   10'h29E
`define PAD_CONV_START_INSTR  10'h29F
`define PAD_WATCHDOG_RESET_INSTR  10'h2A0
// control register slots
`define PAD_IX_K0  4'h0
`define PAD_IX_FR0 4'h3
`define PAD_IX_L1  4'h7
`define PAD_IX_L2  4'h8
`define PAD_IX_J1  4'h9
`define PAD_IX_MR  4'hA
`define PAD_IX_Q1  4'hB
`define PAD_NREG   14
// bit positions
`define PAD_B_MODE 3
`define PAD_B_CONV 2
`define PAD_B_SER  3
// wishbone word offsets
`define PAD_A_IRQ  2'h0
`define PAD_A_STAT 2'h1
`endif

/* File: pad_pkg.sv */
package pad_pkg;
   // decoded operation classes
   typedef enum logic [4:0] {
      OP_NONE, OP_NOP, OP_RD, OP_WR, OP_SIRD, OP_SIWR, OP_SST,
      OP_SERIAL_DONE_SKIP_INSTR, OP_SELECT_CERAMIC_INSTR, OP_SELECT_RC_INSTR, OP_ADRD, OP_ADLO, OP_CMPWR,
      OP_CONV_START_INSTR, OP_CONV_DONE_SKIP_INSTR, OP_POF, OP_RAM_BACKUP_ENTRY_INSTR, OP_POWERDOWN_ARM_INSTR, OP_POWERDOWN_FLAG_SKIP_INSTR,
      OP_WATCHDOG_RESET_INSTR, OP_WATCHDOG_DISABLE_INSTR, OP_RBK, OP_SBK, OP_VOLTAGE_DROP_ENABLE_INSTR
   } pad_op_t;
   typedef struct packed {
      pad_op_t    op;   // operation class
      logic [3:0] ix;   // control register slot
   } pad_dec_t;
   // answer to the cpu core
   typedef struct packed {
      logic       acc_we; // load accumulator A
      logic [3:0] acc;
      logic       b_we;   // load register B
      logic [3:0] b;
      logic       skip;   // skip next instruction
   } pad_ans_t;
   typedef logic [13:0][3:0] pad_ctrl_t;
endpackage

/* File: pad_decoder.sv */
// The Wishbone slave port and the placing of the registers were left to the implementer.
`include "pad_cfg.svh"
`timescale 1ns/1ns
`default_nettype none
module pad_decoder (
   input  wire logic            clk_i,
   input  wire logic            rst_i,
   input  wire logic            ce_i,
   input  wire logic            instr_valid_i,
   input  wire logic [9:0]      instr_i,
   input  wire logic [3:0]      acc_a_i,
   input  wire logic [3:0]      reg_b_i,
   input  wire logic [7:0]      serial_shift_i,
   input  wire logic            serial_done_set_i,
   input  wire logic [9:0]      conv_result_i,
   input  wire logic            conv_done_set_i,
   input  wire logic            watchdog_flag_1_set_i,
   input  wire logic            pd_flag_i,
   input  wire logic            vd_pin_i,
   input  wire logic            wb_cyc_i,
   input  wire logic            wb_stb_i,
   input  wire logic            wb_we_i,
   input  wire logic [3:0]      wb_adr_i,
   input  wire logic [31:0]     wb_dat_i,
   input  wire logic [3:0]      wb_sel_i,
   output var  logic [31:0]     wb_dat_o,
   output var  logic            wb_ack_o,
   output var  pad_pkg::pad_ans_t  ans_o,
   output var  pad_pkg::pad_ctrl_t ctrl_o,
   output var  logic [7:0]      serial_wdata_o,
   output var  logic            serial_we_o,
   output var  logic            serial_start_o,
   output var  logic            serial_done_o,
   output var  logic            conv_start_o,
   output var  logic            conv_cmp_o,
   output var  logic            conv_done_o,
   output var  logic [7:0]      cmp_ref_o,
   output var  logic            cmp_we_o,
   output var  logic            clk_rc_o,
   output var  logic            osc_stop_o,
   output var  logic            clock_mode_o,
   output var  logic            ram_backup_o,
   output var  logic            watchdog_flag_1_o,
   output var  logic            wdt_stop_o,
   output var  logic            bank_o,
   output var  logic            vd_keep_o
);
   // decoding used by the execution group; the checks compare instr_i directly
   function automatic pad_pkg::pad_dec_t decode(input logic [9:0] w);
      pad_pkg::pad_dec_t d;
      d = '{op: pad_pkg::OP_NONE, ix: 4'h0};
      unique case (w)
         `PAD_NOP:   d.op = pad_pkg::OP_NOP;
         `PAD_TAK0:  d = '{pad_pkg::OP_RD, `PAD_IX_K0};
         `PAD_TAK1:  d = '{pad_pkg::OP_RD, `PAD_IX_K0 + 4'h1};
         `PAD_TK0A:  d = '{pad_pkg::OP_WR, `PAD_IX_K0};
         `PAD_TK1A:  d = '{pad_pkg::OP_WR, `PAD_IX_K0 + 4'h1};
         `PAD_TL1A:  d = '{pad_pkg::OP_WR, `PAD_IX_L1};
         `PAD_TL2A:  d = '{pad_pkg::OP_WR, `PAD_IX_L2};
         `PAD_TAL1:  d = '{pad_pkg::OP_RD, `PAD_IX_L1};
         `PAD_TAJ1:  d = '{pad_pkg::OP_RD, `PAD_IX_J1};
         `PAD_TJ1A:  d = '{pad_pkg::OP_WR, `PAD_IX_J1};
         `PAD_TAMR:  d = '{pad_pkg::OP_RD, `PAD_IX_MR};
         `PAD_TMRA:  d = '{pad_pkg::OP_WR, `PAD_IX_MR};
         `PAD_TABSI: d.op = pad_pkg::OP_SIRD;
         `PAD_TSIAB: d.op = pad_pkg::OP_SIWR;
         `PAD_SST:   d.op = pad_pkg::OP_SST;
         `PAD_SERIAL_DONE_SKIP_INSTR: d.op = pad_pkg::OP_SERIAL_DONE_SKIP_INSTR;
         `PAD_SELECT_CERAMIC_INSTR:  d.op = pad_pkg::OP_SELECT_CERAMIC_INSTR;
         `PAD_SELECT_RC_INSTR:  d.op = pad_pkg::OP_SELECT_RC_INSTR;
         `PAD_CONV_RESULT_READ_INSTR: d.op = pad_pkg::OP_ADRD;
         `PAD_CONV_LOW_READ_INSTR:  d.op = pad_pkg::OP_ADLO;
         `PAD_COMPARATOR_WRITE_INSTR: d.op = pad_pkg::OP_CMPWR;
         `PAD_CONV_START_INSTR:  d.op = pad_pkg::OP_CONV_START_INSTR;
         `PAD_CONV_DONE_SKIP_INSTR: d.op = pad_pkg::OP_CONV_DONE_SKIP_INSTR;
         `PAD_POF:   d.op = pad_pkg::OP_POF;
         `PAD_RAM_BACKUP_ENTRY_INSTR:  d.op = pad_pkg::OP_RAM_BACKUP_ENTRY_INSTR;
         `PAD_POWERDOWN_ARM_INSTR:  d.op = pad_pkg::OP_POWERDOWN_ARM_INSTR;
         `PAD_POWERDOWN_FLAG_SKIP_INSTR:  d.op = pad_pkg::OP_POWERDOWN_FLAG_SKIP_INSTR;
         `PAD_WATCHDOG_RESET_INSTR:  d.op = pad_pkg::OP_WATCHDOG_RESET_INSTR;
         `PAD_WATCHDOG_DISABLE_INSTR:  d.op = pad_pkg::OP_WATCHDOG_DISABLE_INSTR;
         `PAD_RBK:   d.op = pad_pkg::OP_RBK;
         `PAD_SBK:   d.op = pad_pkg::OP_SBK;
         `PAD_VOLTAGE_DROP_ENABLE_INSTR:  d.op = pad_pkg::OP_VOLTAGE_DROP_ENABLE_INSTR;
         default: begin
            // wakeup 2, port formats and converter controls by range
            if (w == `PAD_TK1A + 10'h001)
               d = '{pad_pkg::OP_WR, `PAD_IX_K0 + 4'h2};
            else if (w == `PAD_TAK1 + 10'h001)
               d = '{pad_pkg::OP_RD, `PAD_IX_K0 + 4'h2};
            else if (w[9:2] == `PAD_TFR0A >> 2)
               d = '{pad_pkg::OP_WR, `PAD_IX_FR0 + {2'b00, w[1:0]}};
            else if (w[9:2] == `PAD_TQ1A >> 2 && w[1:0] != 2'b11)
               d = '{pad_pkg::OP_WR, `PAD_IX_Q1 + {2'b00, w[1:0]}};
            else if (w[9:2] == `PAD_TAQ1 >> 2 && w[1:0] != 2'b11)
               d = '{pad_pkg::OP_RD, `PAD_IX_Q1 + {2'b00, w[1:0]}};
         end
      endcase
      return d;
   endfunction

   pad_pkg::pad_dec_t dec;       // current decode
   logic              exec;      // instruction really executes
   logic              skip_pend; // next instruction to be dropped
   logic              armed;     // power-down entry armed
   logic              watchdog_disable_instr_prev; // watchdog disable just ran
   logic              vd_en;     // voltage detect kept in power-down
   logic              vd_s1;     // pin synchroniser stages
   logic              vd_s2;
   logic [3:0]        irq_ctrl;  // interrupt enable nibble
   logic              cmp_mode;  // comparator mode bit
   // next values of the execution group
   pad_pkg::pad_ans_t  next_ans;
   pad_pkg::pad_ctrl_t next_ctrl;
   logic [7:0] next_swd, next_cref;
   logic next_swe, next_sst, next_sdone, next_cst, next_ccmp;
   logic next_cdone, next_cwe, next_rc, next_ostop, next_cmode;
   logic next_rbk, next_watchdog_flag_1, next_wstop, next_bank, next_vdk;
   logic next_skp, next_arm, next_dw, next_vden, next_s1, next_s2;

   assign cmp_mode = ctrl_o[`PAD_IX_Q1][`PAD_B_MODE];
   // skipped word is consumed without effect
   assign exec = instr_valid_i && !skip_pend;
   assign dec  = decode(instr_i);

   // execution: compute every next value
   always_comb begin
      next_ans   = '0;
      next_ctrl  = ctrl_o;
      next_swd   = serial_wdata_o;
      next_cref  = cmp_ref_o;
      next_swe   = 1'b0;
      next_sst   = 1'b0;
      next_cst   = 1'b0;
      next_cwe   = 1'b0;
      next_cmode = 1'b0;
      next_rbk   = 1'b0;
      next_ccmp  = conv_cmp_o;
      next_rc    = clk_rc_o;
      next_ostop = osc_stop_o;
      next_wstop = wdt_stop_o;
      next_bank  = bank_o;
      next_vden  = vd_en;
      next_s1    = vd_pin_i;
      next_s2    = vd_s1;
      // hardware set wins over an instruction clear
      next_sdone = serial_done_o | serial_done_set_i;
      next_cdone = conv_done_o | conv_done_set_i;
      next_watchdog_flag_1  = watchdog_flag_1_o | watchdog_flag_1_set_i;
      next_skp   = instr_valid_i ? 1'b0 : skip_pend;
      next_arm   = instr_valid_i ? 1'b0 : armed;
      next_dw    = instr_valid_i ? 1'b0 : watchdog_disable_instr_prev;
      if (exec) begin
         unique case (dec.op)
            pad_pkg::OP_NONE, pad_pkg::OP_NOP: begin
               // other groups or no-operation: nothing here
            end
            pad_pkg::OP_RD: begin
               // readable slots only decode here
               next_ans.acc_we = 1'b1;
               next_ans.acc = ctrl_o[dec.ix];
            end
            pad_pkg::OP_WR:
               next_ctrl[dec.ix] = acc_a_i;
            pad_pkg::OP_SIRD: begin
               next_ans = '{1'b1, serial_shift_i[3:0],
                            1'b1, serial_shift_i[7:4], 1'b0};
            end
            pad_pkg::OP_SIWR: begin
               next_swd = {reg_b_i, acc_a_i};
               next_swe = 1'b1;
            end
            pad_pkg::OP_SST: begin
               next_sdone = serial_done_set_i;
               next_sst   = 1'b1;
            end
            pad_pkg::OP_SERIAL_DONE_SKIP_INSTR:
               if (!irq_ctrl[`PAD_B_SER] && serial_done_o) begin
                  next_ans.skip = 1'b1;
                  next_skp = 1'b1;
                  next_sdone = serial_done_set_i;
               end
            pad_pkg::OP_SELECT_CERAMIC_INSTR, pad_pkg::OP_SELECT_RC_INSTR: begin
               next_rc = dec.op == pad_pkg::OP_SELECT_RC_INSTR;
               next_ostop = 1'b1;
            end
            pad_pkg::OP_ADRD: begin
               next_ans.acc_we = 1'b1;
               next_ans.b_we   = 1'b1;
               if (cmp_mode) begin
                  next_ans.b   = conv_result_i[7:4];
                  next_ans.acc = conv_result_i[3:0];
               end else begin
                  next_ans.b   = conv_result_i[9:6];
                  next_ans.acc = conv_result_i[5:2];
               end
            end
            pad_pkg::OP_ADLO: begin
               next_ans.acc_we = 1'b1;
               next_ans.acc = {conv_result_i[1:0], 2'b00};
            end
            pad_pkg::OP_CMPWR:
               // ignored outside comparator mode
               if (cmp_mode) begin
                  next_cref = {reg_b_i, acc_a_i};
                  next_cwe = 1'b1;
               end
            pad_pkg::OP_CONV_START_INSTR: begin
               next_cdone = conv_done_set_i;
               next_cst  = 1'b1;
               next_ccmp = cmp_mode;
            end
            pad_pkg::OP_CONV_DONE_SKIP_INSTR:
               if (!irq_ctrl[`PAD_B_CONV] && conv_done_o) begin
                  next_ans.skip = 1'b1;
                  next_skp = 1'b1;
                  next_cdone = conv_done_set_i;
               end
            pad_pkg::OP_POF:  next_cmode = armed;
            pad_pkg::OP_RAM_BACKUP_ENTRY_INSTR: next_rbk = armed;
            pad_pkg::OP_POWERDOWN_ARM_INSTR: next_arm = 1'b1;
            pad_pkg::OP_POWERDOWN_FLAG_SKIP_INSTR:
               if (pd_flag_i) begin
                  next_ans.skip = 1'b1;
                  next_skp = 1'b1;
               end
            pad_pkg::OP_WATCHDOG_RESET_INSTR: begin
               if (watchdog_flag_1_o) begin
                  next_ans.skip = 1'b1;
                  next_skp = 1'b1;
                  next_watchdog_flag_1 = watchdog_flag_1_set_i;
               end
               if (watchdog_disable_instr_prev)
                  next_wstop = 1'b1;
            end
            pad_pkg::OP_WATCHDOG_DISABLE_INSTR: next_dw = 1'b1;
            pad_pkg::OP_RBK:  next_bank = 1'b0;
            pad_pkg::OP_SBK:  next_bank = 1'b1;
            pad_pkg::OP_VOLTAGE_DROP_ENABLE_INSTR: next_vden = 1'b1;
         endcase
      end
      // held only while the pin stays high
      next_vdk = next_vden & vd_s2;
   end

   // execution: register
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ans_o <= '0;
         ctrl_o <= '0;
         serial_wdata_o <= 8'h00;
         cmp_ref_o <= 8'h00;
         {serial_we_o, serial_start_o, serial_done_o} <= 3'b000;
         {conv_start_o, conv_cmp_o, conv_done_o} <= 3'b000;
         {cmp_we_o, clk_rc_o, osc_stop_o} <= 3'b000;
         {clock_mode_o, ram_backup_o, watchdog_flag_1_o} <= 3'b000;
         {wdt_stop_o, bank_o, vd_keep_o} <= 3'b000;
         {skip_pend, armed, watchdog_disable_instr_prev} <= 3'b000;
         {vd_en, vd_s1, vd_s2} <= 3'b000;
      end else if (ce_i) begin
         ans_o <= next_ans;
         ctrl_o <= next_ctrl;
         serial_wdata_o <= next_swd;
         cmp_ref_o <= next_cref;
         serial_we_o <= next_swe;
         serial_start_o <= next_sst;
         serial_done_o <= next_sdone;
         conv_start_o <= next_cst;
         conv_cmp_o <= next_ccmp;
         conv_done_o <= next_cdone;
         cmp_we_o <= next_cwe;
         clk_rc_o <= next_rc;
         osc_stop_o <= next_ostop;
         clock_mode_o <= next_cmode;
         ram_backup_o <= next_rbk;
         watchdog_flag_1_o <= next_watchdog_flag_1;
         wdt_stop_o <= next_wstop;
         bank_o <= next_bank;
         vd_keep_o <= next_vdk;
         skip_pend <= next_skp;
         armed <= next_arm;
         watchdog_disable_instr_prev <= next_dw;
         vd_en <= next_vden;
         vd_s1 <= next_s1;
         vd_s2 <= next_s2;
      end
   end

   // wishbone slave: one wait state, unmapped reads zero
   logic [31:0] next_dat;
   logic [3:0]  next_irq;
   logic        next_ack;
   always_comb begin
      next_ack = wb_cyc_i && wb_stb_i && !wb_ack_o;
      next_irq = irq_ctrl;
      next_dat = 32'h0000_0000;
      if (next_ack) begin
         unique case (wb_adr_i[3:2])
            `PAD_A_IRQ: begin
               next_dat[3:0] = irq_ctrl;
               if (wb_we_i && wb_sel_i[0])
                  next_irq = wb_dat_i[3:0];
            end
            `PAD_A_STAT:
               next_dat[7:0] = {vd_en, bank_o, wdt_stop_o, armed,
                                pd_flag_i, watchdog_flag_1_o, conv_done_o,
                                serial_done_o};
            default: next_dat = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
         irq_ctrl <= 4'h0;
      end else if (ce_i) begin
         wb_ack_o <= next_ack;
         wb_dat_o <= next_dat;
         irq_ctrl <= next_irq;
      end
   end

   // checks
   nop_quiet_a: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && exec && instr_i == `PAD_NOP |=> !ans_o.acc_we
      && !ans_o.b_we && !ans_o.skip && $stable(ctrl_o))
      else $error("no-operation changed state");
   wake_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && exec && instr_i == `PAD_TK0A
      |=> ctrl_o[`PAD_IX_K0] == $past(acc_a_i))
      else $error("wakeup register not loaded");
   shift_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && exec && instr_i == `PAD_TABSI |=> ans_o.b_we
      && ans_o.b == $past(serial_shift_i[7:4])
      && ans_o.acc == $past(serial_shift_i[3:0]))
      else $error("shift register read split wrong");
   serial_start_a: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && exec && instr_i == `PAD_SST && !serial_done_set_i
      |=> serial_start_o && !serial_done_o ##1 !serial_start_o)
      else $error("serial start wrong");
   serial_skip_a: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && exec && instr_i == `PAD_SERIAL_DONE_SKIP_INSTR
      |=> ans_o.skip == (!$past(irq_ctrl[`PAD_B_SER])
      && $past(serial_done_o)))
      else $error("serial done test wrong");
   result_split_a: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && exec && instr_i == `PAD_CONV_RESULT_READ_INSTR && !cmp_mode
      |=> ans_o.b == $past(conv_result_i[9:6])
      && ans_o.acc == $past(conv_result_i[5:2]))
      else $error("conversion result split wrong");
   pof_armed_a: assert property (@(posedge clk_i) disable iff (rst_i)
      clock_mode_o || ram_backup_o |-> $past(armed))
      else $error("power-down entered unarmed");
   wdt_stop_a: assert property (@(posedge clk_i) disable iff (rst_i)
      $rose(wdt_stop_o) |-> $past(watchdog_disable_instr_prev))
      else $error("watchdog stopped without disable");
endmodule // pad_decoder
`default_nettype wire

/* File: pad_periph_model.sv */
`timescale 1ns/1ns
`default_nettype none
// stands in for the serial unit and the converter on the far side
module pad_periph_model (
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   input  wire logic       sio_we_i,  // shift register load
   input  wire logic [7:0] sio_wd_i,
   input  wire logic       sio_go_i,  // transfer start
   input  wire logic       ad_go_i,   // conversion start
   input  wire logic [3:0] lat_i,     // completion delay, prompt or slow
   output var  logic [7:0] shift_o,
   output var  logic       sio_set_o, // one-cycle done pulses
   output var  logic       ad_set_o
);
   logic [4:0] sio_cnt;               // cycles left in transfer
   logic [4:0] ad_cnt;                // cycles left in conversion
   // done pulses come only after a start, never unprompted
   always_ff @(posedge clk_i) begin
      sio_set_o <= 1'b0;
      ad_set_o <= 1'b0;
      if (rst_i) begin
         shift_o <= 8'h00;
         sio_cnt <= 5'h00;
         ad_cnt <= 5'h00;
      end else begin
         if (sio_we_i) shift_o <= sio_wd_i;
         if (sio_go_i) sio_cnt <= {1'b0, lat_i} + 5'h01;
         else if (sio_cnt != 5'h00) sio_cnt <= sio_cnt - 5'h01;
         if (sio_cnt == 5'h01) sio_set_o <= 1'b1;
         if (ad_go_i) ad_cnt <= {1'b0, lat_i} + 5'h02;
         else if (ad_cnt != 5'h00) ad_cnt <= ad_cnt - 5'h01;
         if (ad_cnt == 5'h01) ad_set_o <= 1'b1;
      end
   end
endmodule // pad_periph_model
`default_nettype wire

/* File: pad_decoder_tb.sv */
`include "pad_cfg.svh"
`timescale 1ns/1ns
`default_nettype none
module pad_decoder_tb;
   logic clk_i = 1'b0, rst_i = 1'b1, iv = 1'b0, wdf = 1'b0, pdf = 1'b0;
   logic vdp = 1'b0, cyc = 1'b0, stb = 1'b0, wwe = 1'b0;
   logic [9:0] instr = 10'h000, res = 10'h000;
   logic [3:0] acc = 4'h0, rb = 4'h0, adr = 4'h0, lat = 4'h2, a, b;
   logic [31:0] wdat = 32'h0000_0000, q, wb_dat_o;
   logic wb_ack_o, sio_we, sio_go, sio_done, ad_go, ad_cmp, ad_done;
   logic cmp_we, rc, osc, cmode, rbak, watchdog_flag_1, wstop, bank, vkeep;
   logic sio_set, ad_set;
   logic [7:0] sio_wd, shift, cmp_ref;
   pad_pkg::pad_ans_t ans_o;
   pad_pkg::pad_ctrl_t ctrl_o;
   int mismatches = 0, tests_run = 0, n, i, ctl [14];
   // write and read opcodes with their slot; zero read means write-only
   logic [9:0] wr_t [8] = '{`PAD_TK0A, `PAD_TK1A, `PAD_TFR0A, `PAD_TL1A,
      `PAD_TL2A, `PAD_TJ1A, `PAD_TMRA, `PAD_TQ1A};
   logic [9:0] rd_t [8] = '{`PAD_TAK0, `PAD_TAK1, 10'h000, `PAD_TAL1,
      10'h000, `PAD_TAJ1, `PAD_TAMR, `PAD_TAQ1};
   int ix_t [8] = '{0, 1, 3, 7, 8, 9, 10, 11};
   always #25 clk_i = ~clk_i;
   pad_decoder u_pad_decoder (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1),
      .instr_valid_i(iv), .instr_i(instr), .acc_a_i(acc), .reg_b_i(rb),
      .serial_shift_i(shift), .serial_done_set_i(sio_set),
      .conv_result_i(res), .conv_done_set_i(ad_set), .watchdog_flag_1_set_i(wdf),
      .pd_flag_i(pdf), .vd_pin_i(vdp), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(wwe), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(4'hF),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .ans_o(ans_o),
      .ctrl_o(ctrl_o), .serial_wdata_o(sio_wd), .serial_we_o(sio_we),
      .serial_start_o(sio_go), .serial_done_o(sio_done),
      .conv_start_o(ad_go), .conv_cmp_o(ad_cmp), .conv_done_o(ad_done),
      .cmp_ref_o(cmp_ref), .cmp_we_o(cmp_we), .clk_rc_o(rc),
      .osc_stop_o(osc), .clock_mode_o(cmode), .ram_backup_o(rbak),
      .watchdog_flag_1_o(watchdog_flag_1), .wdt_stop_o(wstop), .bank_o(bank), .vd_keep_o(vkeep));
   pad_periph_model u_pad_periph_model (.clk_i(clk_i), .rst_i(rst_i),
      .sio_we_i(sio_we), .sio_wd_i(sio_wd), .sio_go_i(sio_go),
      .ad_go_i(ad_go), .lat_i(lat), .shift_o(shift), .sio_set_o(sio_set),
      .ad_set_o(ad_set));
   // one compare, counted; unknowns never match
   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      tests_run++;
      if (seen !== exp) begin
         mismatches++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic end_of_test();
      $display("checks=%0d mismatches=%0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // issue one word right after a rising edge; valid drops once taken
   // so a later bus cycle never re-executes it; checks run at the
   // falling edge, where the registered answer has settled
   task automatic op(input logic [9:0] w, input logic [3:0] av = 4'h0,
                     input logic [3:0] bv = 4'h0);
      @(posedge clk_i);
      instr <= w;
      acc <= av;
      rb <= bv;
      iv <= 1'b1;
      @(posedge clk_i);
      iv <= 1'b0;
      @(negedge clk_i);
   endtask
   task automatic idle();
      @(posedge clk_i);
      iv <= 1'b0;
      @(negedge clk_i);
   endtask
   // classic single wishbone cycle, held until ack is sampled
   task automatic wb(input logic we, input logic [3:0] ad,
                     input logic [31:0] d);
      int k;
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      wwe <= we;
      adr <= ad;
      wdat <= d;
      for (k = 0; k < 20; k++) begin
         @(posedge clk_i);
         if (wb_ack_o === 1'b1) break;
      end
      q = wb_dat_o;
      if (k == 20) begin
         mismatches++;
         end_of_test();
      end
      // released at the ack edge; next task waits an edge with cyc low
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask
   // a hang anywhere ends the run as a failure
   initial begin
      #5_000_000;
      mismatches++;
      end_of_test();
   end
   initial begin
      void'($urandom(42));
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
      for (i = 0; i < 8; i++) begin
         a = $urandom;
         if (i == 7) a[3] = 1'b0; // start in conversion mode
         ctl[ix_t[i]] = a;
         op(wr_t[i], a);
         chk(ctrl_o[ix_t[i]], ctl[ix_t[i]][3:0]);
         if (rd_t[i] != 10'h000) begin
            op(rd_t[i], ~a);
            chk(ans_o, {1'b1, a, 6'h00});
         end
      end
      op(`PAD_NOP, 4'hF, 4'hF);
      chk(ans_o, 0);
      chk(ctrl_o[`PAD_IX_K0], ctl[0][3:0]);
      a = $urandom;
      b = $urandom;
      op(`PAD_TSIAB, a, b);
      chk({sio_we, sio_wd}, {1'b1, b, a});
      idle();
      op(`PAD_TABSI);
      chk(ans_o, {1'b1, a, 1'b1, b, 1'b0});
      op(`PAD_SST);
      chk({sio_go, sio_done}, 2'b10);
      for (n = 0; n < 40 && sio_done !== 1'b1; n++) idle();
      wb(1'b1, 4'h0, 32'h0000_0008);
      op(`PAD_SERIAL_DONE_SKIP_INSTR);
      chk({ans_o.skip, sio_done}, 2'b01);
      wb(1'b1, 4'h0, 32'h0000_0000);
      op(`PAD_SERIAL_DONE_SKIP_INSTR);
      chk(ans_o.skip, 1'b1);
      op(`PAD_TK0A, ~ctl[0][3:0]);
      chk({sio_done, ctrl_o[`PAD_IX_K0]}, {1'b0, ctl[0][3:0]});
      res = $urandom;
      lat = 4'hC;
      op(`PAD_CONV_START_INSTR);
      chk({ad_go, ad_cmp, ad_done}, 3'b100);
      for (n = 0; n < 40 && ad_done !== 1'b1; n++) idle();
      wb(1'b1, 4'h0, 32'h0000_0004);
      op(`PAD_CONV_DONE_SKIP_INSTR);
      chk({ans_o.skip, ad_done}, 2'b01);
      wb(1'b1, 4'h0, 32'h0000_0000);
      op(`PAD_CONV_DONE_SKIP_INSTR);
      op(`PAD_NOP);
      chk(ad_done, 1'b0);
      op(`PAD_CONV_DONE_SKIP_INSTR);
      chk(ans_o.skip, 1'b0);
      op(`PAD_CONV_RESULT_READ_INSTR);
      chk(ans_o, {1'b1, res[5:2], 1'b1, res[9:6], 1'b0});
      op(`PAD_CONV_LOW_READ_INSTR);
      chk(ans_o, {1'b1, res[1:0], 8'h00});
      op(`PAD_COMPARATOR_WRITE_INSTR, a, b);
      chk(cmp_we, 1'b0);
      op(`PAD_TQ1A, 4'h8);
      op(`PAD_CONV_RESULT_READ_INSTR);
      chk(ans_o, {1'b1, res[3:0], 1'b1, res[7:4], 1'b0});
      op(`PAD_COMPARATOR_WRITE_INSTR, a, b);
      chk({cmp_we, cmp_ref}, {1'b1, b, a});
      op(`PAD_CONV_START_INSTR);
      chk({ad_go, ad_cmp}, 2'b11);
      op(`PAD_SELECT_CERAMIC_INSTR);
      chk({rc, osc}, 2'b01);
      op(`PAD_SELECT_RC_INSTR);
      chk({rc, osc}, 2'b11);
      op(`PAD_POF);
      chk(cmode, 1'b0);
      op(`PAD_POWERDOWN_ARM_INSTR);
      op(`PAD_NOP);
      op(`PAD_POF);
      chk(cmode, 1'b0);
      op(`PAD_POWERDOWN_ARM_INSTR);
      op(`PAD_POF);
      chk(cmode, 1'b1);
      op(`PAD_POWERDOWN_ARM_INSTR);
      op(`PAD_RAM_BACKUP_ENTRY_INSTR);
      chk(rbak, 1'b1);
      pdf <= 1'b1;
      op(`PAD_POWERDOWN_FLAG_SKIP_INSTR);
      chk(ans_o.skip, 1'b1);
      pdf <= 1'b0;
      op(`PAD_SBK);
      chk(bank, 1'b0);
      op(`PAD_POWERDOWN_FLAG_SKIP_INSTR);
      chk(ans_o.skip, 1'b0);
      wdf <= 1'b1;
      idle();
      wdf <= 1'b0;
      op(`PAD_WATCHDOG_RESET_INSTR);
      chk({ans_o.skip, wstop}, 2'b10);
      op(`PAD_NOP);
      chk(watchdog_flag_1, 1'b0);
      op(`PAD_WATCHDOG_DISABLE_INSTR);
      op(`PAD_WATCHDOG_RESET_INSTR);
      chk({ans_o.skip, wstop}, 2'b01);
      op(`PAD_SBK);
      chk(bank, 1'b1);
      op(`PAD_RBK);
      chk(bank, 1'b0);
      vdp <= 1'b1;
      op(`PAD_VOLTAGE_DROP_ENABLE_INSTR);
      repeat (3) idle();
      chk(vkeep, 1'b1);
      vdp <= 1'b0;
      repeat (3) idle();
      chk(vkeep, 1'b0);
      wb(1'b0, 4'h4, 32'h0000_0000);
      chk({q[7], q[5]}, 2'b11);
      wb(1'b1, 4'h0, 32'h0000_0005);
      wb(1'b0, 4'h0, 32'h0000_0000);
      chk(q[3:0], 4'h5);
      wb(1'b0, 4'h8, 32'h0000_0000);
      chk(q, 32'h0000_0000);
      end_of_test();
   end
endmodule // pad_decoder_tb
`default_nettype wire
